// *** core/adc_sequencer_control.v ***
`timescale 1ns/1ps
`include "adc_seq_defines.vh"
// Function
// - Format bit 1 right-justifies, upper six high bits zero; 0 left-justifies.
// - Three-bit clock code picks osc/2..osc/64 or internal RC clock.
// - Port configuration code decodes which of eight channel pins are analog.
// - Port configuration code also chooses reference sources from channels 3, 2.
// - Any reset forces all analog-capable pins to analog input.
// - Conversions continue in sleep only when using the internal RC clock.
// - Result found by successive approximation, one bit per bit period.
// - Reset returns registers to reset values, converter off, conversion dropped.
// - Completion loads result, clears busy bit, sets done flag.
// - Result pair is never initialised by reset.
// - Two bit periods pass after a conversion before acquisition resumes.
// - Hold capacitor disconnects from input when conversion starts.
// - One conversion takes twelve bit periods, the first one partial on the internal RC clock.
// - Bits 5 and 4 of format register read zero.
// - Setting busy bit while powered starts conversion; hardware clears it.
// - Converter-on bit powers converter up or down.
// - Clearing busy bit mid-conversion aborts; result kept; acquisition restarts later.
// - Three-bit channel select maps codes 0..7 to channels 0..7.
module adc_sequencer_control (
  input  wire        clk,
  input  wire        rstn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        sleep_mode,
  input  wire        rc_clock_tick,
  input  wire        comp_above,
  output reg  [9:0]  sar_trial_code,
  output reg         hold_connect,
  output reg         converter_power,
  output reg  [2:0]  channel_select,
  output reg  [7:0]  analog_pin_mask,
  output reg         vref_pos_from_pin,
  output reg         vref_neg_from_pin,
  output reg         conv_done_flag,
  output reg         conv_done_int_enable
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  localparam [2:0] ST_ACQ  = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Terminal count of the oscillator prescaler for a clock code
  function [5:0] div_last;
    input [2:0] code;
    begin
      case (code)
        3'b000:  div_last = 6'h01;
        3'b100:  div_last = 6'h03;
        3'b001:  div_last = 6'h07;
        3'b101:  div_last = 6'h0F;
        3'b010:  div_last = 6'h1F;
        3'b110:  div_last = 6'h3F;
        default: div_last = 6'h00;
      endcase
    end
  endfunction

  // Analog pin map, bit n is channel n
  function [7:0] pin_map;
    input [3:0] code;
    begin
      case (code)
        4'h0, 4'h1, 4'h8: pin_map = 8'hFF;
        4'h2, 4'h3, 4'hC: pin_map = 8'h1F;
        4'h4, 4'h5:       pin_map = 8'h0B;
        4'h9, 4'hA, 4'hB: pin_map = 8'h3F;
        4'hD:             pin_map = 8'h0F;
        4'hE:             pin_map = 8'h01;
        4'hF:             pin_map = 8'h0D;
        default:          pin_map = 8'h00;
      endcase
    end
  endfunction

  // Negative reference from channel 2 for these codes
  function vref_neg_sel;
    input [3:0] code;
    begin
      vref_neg_sel = (code == 4'h8) | (code == 4'hB) | (code == 4'hC) |
                     (code == 4'hD) | (code == 4'hF);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0] control_0_r;
  reg  [7:0] format_port_r;
  reg        done_flag_r;
  reg        int_en_r;
  reg  [9:0] result_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg  [5:0] pre_cnt_r;
  reg  [3:0] tad_cnt_r;
  reg  [1:0] wait_cnt_r;
  reg  [9:0] sar_r;
  reg  [9:0] bit_r;
  reg        wr_pend_r;
  reg  [7:0] wr_addr_r;

  wire [2:0] clk_code  = {format_port_r[`C1_CLK_HI_BIT],
                          control_0_r[`C0_CLK_LO_HI:`C0_CLK_LO_LO]};
  wire       use_rc    = (clk_code[1:0] == 2'b11);
  wire       conv_on   = control_0_r[`C0_ON_BIT];
  wire       fmt_right = format_port_r[`C1_FORMAT_BIT];
  wire [3:0] pcfg      = format_port_r[`C1_PCFG_HI:`C1_PCFG_LO];

  // Bit-period tick; the oscillator halts in sleep so only the RC clock ticks then
  wire osc_tick = (pre_cnt_r == div_last(clk_code)) & ~sleep_mode;
  wire tad_tick = use_rc ? rc_clock_tick : osc_tick;

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states, always OKAY
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire addr_ok  = hsel & hready & htrans[1];
  wire rd_take  = addr_ok & ~hwrite;
  wire wr_take  = addr_ok & hwrite;
  wire wr_c0    = wr_pend_r & (wr_addr_r == `ADDR_CONTROL_0);
  wire wr_c1    = wr_pend_r & (wr_addr_r == `ADDR_FORMAT_PORT);
  wire wr_fl    = wr_pend_r & (wr_addr_r == `ADDR_FLAGS);
  wire wr_go    = hwdata[`C0_GO_BIT];
  wire wr_on    = hwdata[`C0_ON_BIT];

  // Start only from acquisition and if already powered; a go in the wait is dropped
  wire start_req = wr_c0 & wr_go & wr_on & conv_on & (state_r == ST_ACQ);
  wire abort_req = (state_r == ST_CONV) & ((wr_c0 & ~wr_go) | ~conv_on);
  wire finish    = (state_r == ST_CONV) & tad_tick & ~abort_req &
                   (tad_cnt_r == `CONV_TAD_COUNT - 4'h1);

  // Justified views of the stored result
  wire [7:0] res_high = fmt_right ? {6'h00, result_r[9:8]} : result_r[9:2];
  wire [7:0] res_low  = fmt_right ? result_r[7:0] : {result_r[1:0], 6'h00};

  // Address phase captured for the write data phase
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_take;
      wr_addr_r <= haddr[7:0];
    end
  end

  // Read data registered at the address phase; unmapped reads return zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      case (haddr[7:0])
        `ADDR_CONTROL_0:   hrdata <= {24'h000000, control_0_r[7:2], 1'b0, control_0_r[0]};
        `ADDR_FORMAT_PORT: hrdata <= {24'h000000, format_port_r[7:6], 2'b00,
                                      format_port_r[3:0]};
        `ADDR_RESULT_HIGH: hrdata <= {24'h000000, res_high};
        `ADDR_RESULT_LOW:  hrdata <= {24'h000000, res_low};
        `ADDR_FLAGS:       hrdata <= {30'h0000_0000, int_en_r, done_flag_r};
        default:           hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Busy bit follows the sequencer; hardware clears it on completion
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      control_0_r   <= `RST_CONTROL_0;
      format_port_r <= `RST_FORMAT_PORT;
    end else begin
      if (wr_c0) begin
        control_0_r[7:3] <= hwdata[7:3];
        control_0_r[0]   <= wr_on;
      end
      if (start_req)
        control_0_r[`C0_GO_BIT] <= 1'b1;
      else if (finish | abort_req)
        control_0_r[`C0_GO_BIT] <= 1'b0;
      control_0_r[1] <= 1'b0;
      if (wr_c1)
        format_port_r <= {hwdata[7:6], 2'b00, hwdata[3:0]};
    end
  end

  // Done flag: completion wins over a software clear in the same cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_flag_r <= 1'b0;
      int_en_r    <= 1'b0;
    end else begin
      if (finish)
        done_flag_r <= 1'b1;
      else if (wr_fl)
        done_flag_r <= hwdata[`FL_DONE_BIT];
      if (wr_fl)
        int_en_r <= hwdata[`FL_INT_EN_BIT];
    end
  end

  // Result holds no reset so power-on leaves it unknown
  always @(posedge clk) begin
    if (finish)
      result_r <= sar_r & ~(bit_r & {10{~comp_above}});
  end

  // ----------------------------------------------------------------
  // Bit-period prescaler
  // ----------------------------------------------------------------
  // Restarted at each start so the first bit period is a full one
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      pre_cnt_r <= 6'h00;
    else if (start_req | osc_tick)
      pre_cnt_r <= 6'h00;
    else if (~sleep_mode)
      pre_cnt_r <= pre_cnt_r + 6'h01;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_ACQ: begin
        if (start_req)
          state_nxt = ST_CONV;
      end
      ST_CONV: begin
        if (finish | abort_req)
          state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        if (tad_tick & (wait_cnt_r == `POST_WAIT_TAD - 2'h1))
          state_nxt = ST_ACQ;
      end
      default: state_nxt = ST_ACQ;
    endcase
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r    <= ST_ACQ;
      tad_cnt_r  <= 4'h0;
      wait_cnt_r <= 2'h0;
      sar_r      <= 10'h000;
      bit_r      <= 10'h000;
    end else begin
      state_r <= state_nxt;
      case (state_r)
        ST_ACQ: begin
          tad_cnt_r  <= 4'h0;
          wait_cnt_r <= 2'h0;
          if (start_req) begin
            sar_r <= 10'h200;
            bit_r <= 10'h200;
          end
        end
        ST_CONV: begin
          wait_cnt_r <= 2'h0;
          if (tad_tick) begin
            tad_cnt_r <= tad_cnt_r + 4'h1;
            // One bit resolved per period, MSB first, last bit one period before completion
            if (tad_cnt_r >= `SAR_FIRST_TAD && tad_cnt_r <= `SAR_LAST_TAD) begin
              if (!comp_above)
                sar_r <= (sar_r & ~bit_r) | (bit_r >> 1);
              else
                sar_r <= sar_r | (bit_r >> 1);
              if (tad_cnt_r != `SAR_LAST_TAD)
                bit_r <= bit_r >> 1;
            end
          end
        end
        ST_WAIT: begin
          tad_cnt_r <= 4'h0;
          if (tad_tick)
            wait_cnt_r <= wait_cnt_r + 2'h1;
        end
        default: begin
          tad_cnt_r  <= 4'h0;
          wait_cnt_r <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Analog-side controls
  // ----------------------------------------------------------------
  // Hold switch opens on start and stays open through the post-conversion wait
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_connect         <= 1'b0;
      converter_power      <= 1'b0;
      channel_select       <= 3'h0;
      analog_pin_mask      <= 8'hFF;
      vref_pos_from_pin    <= 1'b0;
      vref_neg_from_pin    <= 1'b0;
      sar_trial_code       <= 10'h000;
      conv_done_flag       <= 1'b0;
      conv_done_int_enable <= 1'b0;
    end else begin
      hold_connect         <= conv_on & (state_nxt == ST_ACQ);
      converter_power      <= conv_on;
      channel_select       <= control_0_r[`C0_CHAN_HI:`C0_CHAN_LO];
      analog_pin_mask      <= pin_map(pcfg);
      vref_pos_from_pin    <= (pcfg == 4'h1) | (pcfg == 4'h3) | (pcfg == 4'h5) |
                              (pcfg == 4'hA) | vref_neg_sel(pcfg);
      vref_neg_from_pin    <= vref_neg_sel(pcfg);
      sar_trial_code       <= sar_r;
      conv_done_flag       <= done_flag_r;
      conv_done_int_enable <= int_en_r;
    end
  end

endmodule

// *** core/adc_seq_defines.vh ***
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL_0      8'h00
`define ADDR_FORMAT_PORT    8'h04
`define ADDR_RESULT_HIGH    8'h08
`define ADDR_RESULT_LOW     8'h0C
`define ADDR_FLAGS          8'h10

// ----------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------
`define C0_CLK_LO_HI        7
`define C0_CLK_LO_LO        6
`define C0_CHAN_HI          5
`define C0_CHAN_LO          3
`define C0_GO_BIT           2
`define C0_ON_BIT           0

// ----------------------------------------------------------------
// Format and port configuration register fields
// ----------------------------------------------------------------
`define C1_FORMAT_BIT       7
`define C1_CLK_HI_BIT       6
`define C1_PCFG_HI          3
`define C1_PCFG_LO          0

// ----------------------------------------------------------------
// Flag register fields
// ----------------------------------------------------------------
`define FL_DONE_BIT         0
`define FL_INT_EN_BIT       1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CONTROL_0       8'h00
`define RST_FORMAT_PORT     8'h00

// ----------------------------------------------------------------
// Timing counts, in conversion bit periods
// ----------------------------------------------------------------
`define CONV_TAD_COUNT      4'hC
`define POST_WAIT_TAD       2'h2
`define SAR_FIRST_TAD       4'h1
`define SAR_LAST_TAD        4'hA

`endif

// *** verification/adc_seq_props.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checker
// ------------------------------------------------------------
module adc_seq_props (
  input wire        clk,
  input wire        rstn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hold_connect,
  input wire        converter_power,
  input wire [2:0]  channel_select,
  input wire [7:0]  analog_pin_mask,
  input wire        vref_pos_from_pin,
  input wire        vref_neg_from_pin,
  input wire        conv_done_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Control write: address phase, then its data phase
  sequence wr_ctl;
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00 ##1 1'b1;
  endsequence
  sequence conv_end;
    $rose(conv_done_flag);
  endsequence
  sequence hold_cut;
    $fell(hold_connect) && converter_power;
  endsequence
  a_reset_analog: assert property (!$past(rstn) |-> analog_pin_mask == 8'hFF)
    else $error("pins not analog after reset");
  a_chan_follow: assert property (wr_ctl |-> ##2 channel_select == $past(hwdata[5:3], 2))
    else $error("channel select not taken from write");
  a_power_follow: assert property (wr_ctl |-> ##2 converter_power == $past(hwdata[0], 2))
    else $error("power bit not taken from write");
  a_off_no_hold: assert property (!converter_power [*3] |-> !hold_connect)
    else $error("hold connected while off");
  a_done_disc: assert property (conv_end |-> !hold_connect && converter_power)
    else $error("completion with hold connected");
  a_wait_done: assert property (conv_end |-> !hold_connect [*3])
    else $error("acquisition resumed too early");
  a_hold_gap: assert property (hold_cut |-> !hold_connect [*4])
    else $error("hold reconnected too early");
  a_vref_pair: assert property (vref_neg_from_pin |-> vref_pos_from_pin)
    else $error("negative reference without positive");
  a_digital_refs: assert property (analog_pin_mask == 8'h00 |-> !vref_pos_from_pin)
    else $error("reference pin on all-digital code");
endmodule

// *** verification/analog_side.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Analog inputs, comparator and internal RC clock
// ------------------------------------------------------------
module analog_side #(
  parameter RC_DIV = 400  // 1.6 us bit period at 4 ns
) (
  input  wire       clk,
  input  wire       rstn,
  input  wire       hold_connect,
  input  wire [9:0] sar_trial_code,
  input  wire [9:0] pin_level,
  output reg        rc_clock_tick,
  output wire       comp_above
);
  localparam logic [8:0] RC_LAST = RC_DIV - 1;
  reg [9:0] held_r;
  reg [8:0] rc_cnt_r;
  // Capacitor tracks the pin while tied, keeps its charge once cut off
  always @(posedge clk) begin
    if (hold_connect) held_r <= pin_level;
  end
  assign comp_above = (held_r >= sar_trial_code);
  // RC clock runs free, unrelated to the oscillator prescaler
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rc_cnt_r      <= 9'h000;
      rc_clock_tick <= 1'b0;
    end else begin
      rc_cnt_r      <= (rc_cnt_r == RC_LAST) ? 9'h000 : rc_cnt_r + 9'h001;
      rc_clock_tick <= (rc_cnt_r == RC_LAST);
    end
  end
endmodule

// *** verification/tb_adc_sequencer_control.sv ***
`timescale 1ns/1ps
`include "adc_seq_defines.vh"
module tb_adc_sequencer_control;
  logic        clk = 0, rstn = 0, hsel = 0, hwrite = 0, sleep_mode = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0]  htrans = 0;
  logic [9:0]  pin_level = 10'h000;  // Pins only ever feed the converter
  wire         hreadyout, hresp, rc_clock_tick, comp_above, hold_connect, converter_power;
  wire         vpos, vneg, conv_done_flag, conv_done_int_enable;
  wire  [31:0] hrdata;
  wire  [9:0]  sar_trial_code;
  wire  [2:0]  channel_select;
  wire  [7:0]  analog_pin_mask;
  int          fail_count = 0, tests_run = 0, n2, n4, n;
  logic [11:0] masks [5] = '{12'h0FF, 12'h21F, 12'h600, 12'h93F, 12'hE01};
  logic [5:0]  refs [3] = '{6'h00, 6'h0E, 6'h2F};
  // Clock code in [9:7], oscillator divisor in [6:0]
  logic [9:0]  divs [4] = '{10'h088, 10'h290, 10'h120, 10'h340};
  adc_sequencer_control adc_sequencer_control_inst (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sleep_mode(sleep_mode), .rc_clock_tick(rc_clock_tick), .comp_above(comp_above),
    .sar_trial_code(sar_trial_code), .hold_connect(hold_connect),
    .converter_power(converter_power), .channel_select(channel_select),
    .analog_pin_mask(analog_pin_mask), .vref_pos_from_pin(vpos), .vref_neg_from_pin(vneg),
    .conv_done_flag(conv_done_flag), .conv_done_int_enable(conv_done_int_enable));
  analog_side analog_side_inst (.clk(clk), .rstn(rstn), .hold_connect(hold_connect),
    .sar_trial_code(sar_trial_code), .pin_level(pin_level),
    .rc_clock_tick(rc_clock_tick), .comp_above(comp_above));
  initial begin
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Bus, comparison and closing tasks
  // ------------------------------------------------------------
  task automatic bus(input [7:0] a, input w, input [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input [7:0] a, input [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic res(input [7:0] h, input [7:0] l);
    rdc(`ADDR_RESULT_HIGH, {24'h0, h});
    rdc(`ADDR_RESULT_LOW, {24'h0, l});
  endtask
  // Power up, clear the flag, let the channel settle, then start: go on the power write is ignored
  task automatic go(input [7:0] c);
    bus(`ADDR_CONTROL_0, 1'b1, {24'h0, c[7:3], 3'b001});
    bus(`ADDR_FLAGS, 1'b1, 32'h0);
    repeat (20) @(posedge clk);
    bus(`ADDR_CONTROL_0, 1'b1, {24'h0, c[7:3], 3'b101});
  endtask
  task automatic wait_done(output int k);
    k = 0;
    while (conv_done_flag !== 1'b1 && k < 6000) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d, comparisons %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_config;
    rdc(`ADDR_CONTROL_0, 32'h0);
    rdc(`ADDR_FORMAT_PORT, 32'h0);
    rdc(8'h20, 32'h0);
    chk(analog_pin_mask, 32'hFF);
    chk(converter_power, 32'h0);
    chk(hresp, 32'h0);
    bus(`ADDR_CONTROL_0, 1'b1, 32'h28);
    repeat (3) @(posedge clk);
    chk(channel_select, 32'h5);
    rdc(`ADDR_CONTROL_0, 32'h28);
    bus(`ADDR_FORMAT_PORT, 1'b1, 32'hFF);
    rdc(`ADDR_FORMAT_PORT, 32'hCF);
    for (int i = 0; i < 5; i++) begin
      bus(`ADDR_FORMAT_PORT, 1'b1, {28'h0, masks[i][11:8]});
      repeat (3) @(posedge clk);
      chk(analog_pin_mask, masks[i][7:0]);
    end
    for (int i = 0; i < 3; i++) begin
      bus(`ADDR_FORMAT_PORT, 1'b1, {28'h0, refs[i][5:2]});
      repeat (3) @(posedge clk);
      chk({vpos, vneg}, refs[i][1:0]);
    end
    bus(`ADDR_FLAGS, 1'b1, 32'h2);
    repeat (3) @(posedge clk);
    chk(conv_done_int_enable, 32'h1);
  endtask
  // Two oscillator codes: only the bit period differs, so twelve periods show as a gap
  task automatic t_convert;
    pin_level <= 10'h2A5;
    bus(`ADDR_FORMAT_PORT, 1'b1, 32'h80);
    go(8'h00);
    wait_done(n2);
    chk(conv_done_flag, 32'h1);
    rdc(`ADDR_CONTROL_0, 32'h01);
    res(8'h02, 8'hA5);
    bus(`ADDR_FORMAT_PORT, 1'b1, 32'h00);
    res(8'hA9, 8'h40);
    pin_level <= 10'h155;
    bus(`ADDR_FORMAT_PORT, 1'b1, 32'h40);
    go(8'h00);
    wait_done(n4);
    chk(n4 - n2, 32'd24);
    res(8'h55, 8'h40);
    // Other oscillator codes: twelve periods, plus two cycles of flag and sampling lag
    for (int i = 0; i < 4; i++) begin
      bus(`ADDR_FORMAT_PORT, 1'b1, {24'h0, 1'b0, divs[i][9], 6'h00});
      go({divs[i][8:7], 6'h00});
      wait_done(n);
      chk(n, 12 * divs[i][6:0] + 2);
      // Let the post-conversion wait end before the clock code changes again
      repeat (140) @(posedge clk);
    end
  endtask
  task automatic t_sleep;
    sleep_mode <= 1'b1;
    pin_level <= 10'h0F0;
    bus(`ADDR_FORMAT_PORT, 1'b1, 32'h00);
    go(8'hC0);
    wait_done(n);
    chk(conv_done_flag, 32'h1);
    res(8'h3C, 8'h00);
    // The RC wait after completion is long; the start below would be dropped inside it
    repeat (900) @(posedge clk);
    chk(hold_connect, 32'h1);
    go(8'h00);
    repeat (100) @(posedge clk);
    chk(conv_done_flag, 32'h0);
    sleep_mode <= 1'b0;
    wait_done(n);
    chk(conv_done_flag, 32'h1);
  endtask
  task automatic t_abort_and_reset;
    pin_level <= 10'h3FF;
    go(8'h00);
    repeat (8) @(posedge clk);
    bus(`ADDR_CONTROL_0, 1'b1, 32'h01);
    repeat (60) @(posedge clk);
    chk(conv_done_flag, 32'h0);
    chk(hold_connect, 32'h1);
    res(8'h3C, 8'h00);
    bus(`ADDR_CONTROL_0, 1'b1, 32'h00);
    bus(`ADDR_CONTROL_0, 1'b1, 32'h05);
    repeat (60) @(posedge clk);
    chk(conv_done_flag, 32'h0);
    rdc(`ADDR_CONTROL_0, 32'h01);
    go(8'h00);
    repeat (6) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk(analog_pin_mask, 32'hFF);
    rdc(`ADDR_CONTROL_0, 32'h0);
    res(8'h3C, 8'h00);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset_and_config();
    t_convert();
    t_sleep();
    t_abort_and_reset();
    end_sim();
  end
  // Watchdog: whole run needs under ten thousand cycles
  initial begin
    repeat (50000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule
bind adc_sequencer_control adc_seq_props adc_seq_props_inst (.clk(clk), .rstn(rstn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hold_connect(hold_connect), .converter_power(converter_power),
  .channel_select(channel_select), .analog_pin_mask(analog_pin_mask),
  .vref_pos_from_pin(vref_pos_from_pin), .vref_neg_from_pin(vref_neg_from_pin),
  .conv_done_flag(conv_done_flag));
